// [hw/odl_dac_end.sv]
// Converter end: serial input shift register, chain output and channel registers.
`timescale 1ns/1ps
module odl_dac_end
  import odl_pkg::*;
(
  // System clock domain
  input  wire logic                     CLK,
  input  wire logic                     RST,
  input  wire logic                     CE,
  // Link
  odl_link_if.dac                       LINK,
  // User side
  output logic [NUM_CH*CODE_W-1:0]      DAC_CODES,
  output logic [NUM_CH*CODE_W-1:0]      INPUT_CODES,
  output logic                          WORD_TAKEN
);

  // ************************************************************
  // Link domain, clocked by falling shift-clock edges
  // ************************************************************
  logic [WORD_BITS-1:0] shreg_q;
  logic [3:0]           bitcnt_q;
  logic [WORD_BITS-1:0] hold_q;
  logic                 tog_q;
  logic [WORD_BITS-1:0] next_word;

  assign next_word = {shreg_q[WORD_BITS-2:0], LINK.serial_data_in};

  // The shift register is never cleared between words, so earlier
  // words keep flowing out to the next device of a chain.
  always_ff @(negedge LINK.serial_shift_clock or posedge RST) begin
    if (RST) begin
      shreg_q <= WORD_RST;
    end else if (!LINK.frame_sync_n) begin
      shreg_q <= next_word;
    end
  end

  // Raising the frame ends a partial word even if the clock has stopped.
  always_ff @(negedge LINK.serial_shift_clock or posedge RST or posedge LINK.frame_sync_n) begin
    if (RST || LINK.frame_sync_n) begin
      bitcnt_q <= 4'h0;
    end else begin
      bitcnt_q <= bitcnt_q + 4'h1;
    end
  end

  always_ff @(negedge LINK.serial_shift_clock or posedge RST) begin
    if (RST) begin
      hold_q <= WORD_RST;
      tog_q  <= 1'b0;
    end else if (!LINK.frame_sync_n && bitcnt_q == LAST_BIT &&
                 next_word[SEL_BIT] == LINK.device_select_pin) begin
      hold_q <= next_word;
      tog_q  <= ~tog_q;
    end
  end

  assign LINK.serial_chain_out = shreg_q[WORD_BITS-1];

  // ************************************************************
  // Crossing into the system clock domain
  // ************************************************************
  logic [2:0] tog_sync_q;
  logic [1:0] upd_sync_q;
  logic [1:0] clr_sync_q;
  logic       word_evt;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tog_sync_q <= 3'h0;
      upd_sync_q <= 2'h3;
      clr_sync_q <= 2'h3;
    end else if (CE) begin
      tog_sync_q <= {tog_sync_q[1:0], tog_q};
      upd_sync_q <= {upd_sync_q[0], LINK.output_update_strobe_n};
      clr_sync_q <= {clr_sync_q[0], LINK.output_clear_n};
    end
  end

  // The held word stays still for a whole word time, far longer
  // than the toggle takes to cross, so it is read without its own sync.
  assign word_evt = tog_sync_q[2] ^ tog_sync_q[1];

  // ************************************************************
  // Input and output registers, one pair per channel
  // ************************************************************
  logic [CH_W-1:0] wr_ch;
  assign wr_ch = hold_q[CH_LSB +: CH_W];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [CODE_W-1:0] in_q;
    logic [CODE_W-1:0] out_q;

    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        in_q <= CODE_RST;
      end else if (CE) begin
        if (!clr_sync_q[1]) begin
          in_q <= CODE_RST;
        end else if (word_evt && wr_ch == CH_W'(c)) begin
          in_q <= hold_q[CODE_LSB +: CODE_W];
        end
      end
    end

    // A low strobe is level sensitive: the outputs follow the inputs.
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        out_q <= CODE_RST;
      end else if (CE) begin
        if (!clr_sync_q[1]) begin
          out_q <= CODE_RST;
        end else if (!upd_sync_q[1]) begin
          out_q <= in_q;
        end
      end
    end

    assign DAC_CODES[c*CODE_W +: CODE_W]   = out_q;
    assign INPUT_CODES[c*CODE_W +: CODE_W] = in_q;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WORD_TAKEN <= 1'b0;
    end else if (CE) begin
      WORD_TAKEN <= word_evt;
    end
  end

endmodule

// [hw/odl_host_end.sv]
// Host end: frames words onto the serial link, pulses strobes, gathers readback.
//
// Contract
// - Frame sync drops before a word's first bit.
// - Data is valid at each falling clock edge.
// - Byte mode keeps frame low between both bytes.
// - Each byte gives exactly eight falling edges.
// - Frame rises after the second byte completes.
// - Words go out most significant bit first.
// - Load strobe low moves inputs to outputs.
// - Clock idles low, data changes on rising.
// - Data shifts out on rising clock edges.
// - Word bit three must match device select pin.
// - Shifted data reappears on chain output.
// - A full chain returns earlier words for readback.
// - Host steers select pins, retransmitting first words; the code drives one select pin and never retransmits.
// - Multi-word loads keep frame low until last.
`timescale 1ns/1ps
module odl_host_end
  import odl_pkg::*;
#(
  parameter int DIV_HALF = DIV_HALF_DEF
)(
  // System clock domain
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire logic                 CE,
  // Word request
  input  wire logic                 WORD_VALID,
  input  wire logic [WORD_BITS-1:0] WORD_DATA,
  input  wire logic                 WORD_LSB_FIRST,
  input  wire logic                 BYTE_MODE,
  input  wire logic                 HOLD_FRAME,
  input  wire logic                 SELECT_LEVEL,
  // Strobe requests
  input  wire logic                 UPDATE_REQ,
  input  wire logic                 CLEAR_REQ,
  output logic                      REQ_READY,
  output logic                      BUSY,
  // Readback
  output logic [WORD_BITS-1:0]      RB_DATA,
  output logic                      RB_VALID,
  // Link
  odl_link_if.host                  LINK
);

  // ************************************************************
  // Types and helpers
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEAD  = 3'h1,
    ST_HIGH  = 3'h2,
    ST_LOW   = 3'h3,
    ST_GAP   = 3'h4,
    ST_TAIL  = 3'h5,
    ST_PULSE = 3'h6
  } odl_state_e;

  typedef logic [7:0] odl_timer_t;

  localparam odl_timer_t HALF_LOAD = odl_timer_t'(DIV_HALF - 1);

  function automatic logic [WORD_BITS-1:0] odl_reverse(input logic [WORD_BITS-1:0] w);
    logic [WORD_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_BITS; i++) begin
      r[i] = w[WORD_BITS-1-i];
    end
    return r;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  odl_state_e           state_q;
  odl_timer_t           timer_q;
  logic [3:0]           bitn_q;
  logic [WORD_BITS-1:0] tx_q;
  logic [WORD_BITS-1:0] rx_q;
  logic                 byte_mode_q;
  logic                 hold_q;
  logic                 pulse_upd_q;
  logic                 sclk_q;
  logic                 sdi_q;
  logic                 frame_n_q;
  logic                 upd_n_q;
  logic                 clr_n_q;
  logic                 sel_q;
  logic [1:0]           sdo_sync_q;
  logic                 tick;
  logic                 take_word;
  logic                 take_upd;
  logic                 take_clr;

  assign tick      = (timer_q == '0);
  assign REQ_READY = CE && (state_q == ST_IDLE);
  assign take_word = REQ_READY && WORD_VALID;
  assign take_upd  = REQ_READY && !WORD_VALID && UPDATE_REQ;
  assign take_clr  = REQ_READY && !WORD_VALID && !UPDATE_REQ && CLEAR_REQ;
  assign BUSY      = (state_q != ST_IDLE);

  // ************************************************************
  // Chain output synchroniser
  // ************************************************************
  // The returned bit is read only at the end of a high phase, at
  // least three cycles after it last moved, so the two-stage delay
  // never loses it.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sdo_sync_q <= 2'h0;
    end else if (CE) begin
      sdo_sync_q <= {sdo_sync_q[0], LINK.serial_chain_out};
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      timer_q <= '0;
      bitn_q  <= 4'h0;
    end else if (CE) begin
      if (!tick) begin
        timer_q <= timer_q - odl_timer_t'(1);
      end
      unique case (state_q)
        ST_IDLE: begin
          if (take_word) begin
            state_q <= ST_LEAD;
            timer_q <= HALF_LOAD;
            bitn_q  <= 4'h0;
          end else if (take_upd || take_clr) begin
            state_q <= ST_PULSE;
            timer_q <= odl_timer_t'(STROBE_CYCLES - 4'h1);
          end
        end
        ST_LEAD: begin
          if (tick) begin
            state_q <= ST_HIGH;
            timer_q <= HALF_LOAD;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            state_q <= ST_LOW;
            timer_q <= HALF_LOAD;
          end
        end
        ST_LOW: begin
          if (tick) begin
            timer_q <= HALF_LOAD;
            if (bitn_q == LAST_BIT) begin
              state_q <= ST_TAIL;
            end else if (byte_mode_q && bitn_q == BYTE_LAST) begin
              state_q <= ST_GAP;
            end else begin
              state_q <= ST_HIGH;
              bitn_q  <= bitn_q + 4'h1;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            state_q <= ST_HIGH;
            timer_q <= HALF_LOAD;
            bitn_q  <= bitn_q + 4'h1;
          end
        end
        ST_TAIL: begin
          if (tick) begin
            state_q <= ST_IDLE;
          end
        end
        ST_PULSE: begin
          if (tick) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Request capture
  // ************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      byte_mode_q <= 1'b0;
      hold_q      <= 1'b0;
      pulse_upd_q <= 1'b0;
      sel_q       <= 1'b0;
    end else if (CE) begin
      if (take_word) begin
        byte_mode_q <= BYTE_MODE;
        hold_q      <= HOLD_FRAME;
        sel_q       <= SELECT_LEVEL;
      end
      if (take_upd || take_clr) begin
        pulse_upd_q <= take_upd;
      end
    end
  end

  // ************************************************************
  // Serial clock and data
  // ************************************************************
  // Clock polarity 0: idle low, data changes as the clock rises and
  // stands for the whole high phase across the falling edge.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_q <= 1'b0;
      sdi_q  <= 1'b0;
      tx_q   <= WORD_RST;
    end else if (CE) begin
      if (take_word) begin
        tx_q <= WORD_LSB_FIRST ? odl_reverse(WORD_DATA) : WORD_DATA;
      end else if (tick && (state_q == ST_LEAD || state_q == ST_GAP ||
                   (state_q == ST_LOW && bitn_q != LAST_BIT &&
                    !(byte_mode_q && bitn_q == BYTE_LAST)))) begin
        sclk_q <= 1'b1;
        sdi_q  <= tx_q[WORD_BITS-1];
        tx_q   <= {tx_q[WORD_BITS-2:0], 1'b0};
      end else if (tick && state_q == ST_HIGH) begin
        sclk_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Frame sync
  // ************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      frame_n_q <= 1'b1;
    end else if (CE) begin
      if (take_word) begin
        frame_n_q <= 1'b0;
      end else if (state_q == ST_LOW && tick && bitn_q == LAST_BIT) begin
        frame_n_q <= !hold_q;
      end
    end
  end

  // ************************************************************
  // Load and clear strobes
  // ************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      upd_n_q <= 1'b1;
      clr_n_q <= 1'b1;
    end else if (CE) begin
      upd_n_q <= !take_upd && !(state_q == ST_PULSE && pulse_upd_q && !tick);
      clr_n_q <= !take_clr && !(state_q == ST_PULSE && !pulse_upd_q && !tick);
    end
  end

  // ************************************************************
  // Readback
  // ************************************************************
  // Each returned bit is taken just before the falling edge that
  // would move it, so the word comes back most significant bit first.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_q     <= WORD_RST;
      RB_DATA  <= WORD_RST;
      RB_VALID <= 1'b0;
    end else if (CE) begin
      RB_VALID <= 1'b0;
      if (state_q == ST_HIGH && tick) begin
        rx_q <= {rx_q[WORD_BITS-2:0], sdo_sync_q[1]};
      end
      if (state_q == ST_LOW && tick && bitn_q == LAST_BIT) begin
        RB_DATA  <= rx_q;
        RB_VALID <= 1'b1;
      end
    end
  end

  assign LINK.serial_shift_clock     = sclk_q;
  assign LINK.serial_data_in         = sdi_q;
  assign LINK.frame_sync_n           = frame_n_q;
  assign LINK.output_update_strobe_n = upd_n_q;
  assign LINK.output_clear_n         = clr_n_q;
  assign LINK.device_select_pin      = sel_q;

endmodule

// [pkg/odl_link_if.sv]
// Serial link between the host end and the converter end.
`timescale 1ns/1ps
interface odl_link_if;
  logic frame_sync_n;
  logic serial_shift_clock;
  logic serial_data_in;
  logic serial_chain_out;
  logic output_update_strobe_n;
  logic output_clear_n;
  logic device_select_pin;

  modport host (
    output frame_sync_n,
    output serial_shift_clock,
    output serial_data_in,
    input  serial_chain_out,
    output output_update_strobe_n,
    output output_clear_n,
    output device_select_pin
  );

  modport dac (
    input  frame_sync_n,
    input  serial_shift_clock,
    input  serial_data_in,
    output serial_chain_out,
    input  output_update_strobe_n,
    input  output_clear_n,
    input  device_select_pin
  );
endinterface

// [pkg/odl_pkg.sv]
// Shared constants for the serial DAC load path.
package odl_pkg;

  // ************************************************************
  // Word layout
  // ************************************************************
  localparam int          WORD_BITS  = 16;
  localparam int          BYTE_BITS  = 8;
  localparam int          NUM_CH     = 8;
  localparam int          CH_W       = 3;
  localparam int          CODE_W     = 12;
  localparam int          CH_LSB     = 0;
  localparam int          SEL_BIT    = 3;
  localparam int          CODE_LSB   = 4;
  localparam logic [3:0]  LAST_BIT   = 4'hf;
  localparam logic [3:0]  BYTE_LAST  = 4'h7;

  // ************************************************************
  // Timing in CLK cycles
  // ************************************************************
  localparam int          DIV_HALF_DEF  = 4;
  localparam logic [3:0]  STROBE_CYCLES = 4'h2;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
  localparam logic [CODE_W-1:0]    CODE_RST = 12'h000;

endpackage

// [verification/odl_link_props.sv]
// Concurrent checks on the link between the host end and the first converter end.
`timescale 1ns/1ps
module odl_link_props #(
  parameter int DIV_HALF = 4
)(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Link
  input wire logic frame_sync_n,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic serial_chain_out,
  input wire logic output_update_strobe_n
);
  logic        sclk_q;
  logic [3:0]  falls_q;
  logic [15:0] hist_q;
  int          high_q;
  wire         fall_w = sclk_q && !serial_shift_clock;

  // ************************************************************
  // Edge history
  // ************************************************************
  // The link clock is a divided system clock, so sampling on CLK sees every edge.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) sclk_q <= 1'b0;
    else sclk_q <= serial_shift_clock;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) falls_q <= 4'h0;
    else if (frame_sync_n) falls_q <= 4'h0;
    else if (fall_w) falls_q <= falls_q + 4'h1;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) hist_q <= 16'h0000;
    else if (fall_w && !frame_sync_n) hist_q <= {hist_q[14:0], serial_data_in};
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) high_q <= 0;
    else if (serial_shift_clock) high_q <= high_q + 1;
    else high_q <= 0;
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence lead_s;
    !serial_shift_clock [*4] ##1 serial_shift_clock;
  endsequence

  sequence strobe_s;
    !output_update_strobe_n [*2] ##1 output_update_strobe_n;
  endsequence

  chk_idle_clock_low: assert property (frame_sync_n |-> !serial_shift_clock)
    else $error("link clock high while frame idle");
  chk_rise_in_frame: assert property ($rose(serial_shift_clock) |-> !frame_sync_n)
    else $error("clock rise outside frame");
  chk_lead_before_clk: assert property ($fell(frame_sync_n) |-> lead_s)
    else $error("frame lead time wrong");
  chk_data_held_fall: assert property ($fell(serial_shift_clock) |-> $stable(serial_data_in))
    else $error("data moved at falling edge");
  chk_high_phase_len: assert property ($fell(serial_shift_clock) |-> high_q == DIV_HALF)
    else $error("clock high phase length wrong");
  chk_frame_word_edges: assert property ($rose(frame_sync_n) |-> falls_q == 4'h0)
    else $error("frame released mid word");
  chk_chain_follows_data: assert property ($fell(serial_shift_clock) |-> serial_chain_out == hist_q[14])
    else $error("chain output not delayed input");
  chk_chain_moves_fall: assert property ($changed(serial_chain_out) |-> $fell(serial_shift_clock))
    else $error("chain output moved off falling edge");
  chk_strobe_pulse: assert property ($fell(output_update_strobe_n) |-> strobe_s)
    else $error("update strobe width wrong");
endmodule

// [verification/tb_octal_dac_serial_loader.sv]
// Self-checking bench: host end driving two chained converter ends.
`timescale 1ns/1ps
module tb_octal_dac_serial_loader;
  import odl_pkg::*;
  localparam int H = 4;

  logic        clk = 1'b0;
  logic        rst, ce, wvalid, lsb, byt, hold, sel, upd, clr, glk, sel_b;
  logic        ready, rb_valid, tk1, tk2, busy;
  logic [15:0] wdata, rb_data, last_w, w, keep;
  logic [95:0] codes1, in1, codes2, in2;
  logic [95:0] rbq [$];
  logic [95:0] q1 [$];
  logic [95:0] q2 [$];
  logic [11:0] m1 [8];
  logic [11:0] m2 [8];
  int          errors, check_count, seed;

  odl_link_if link_a ();
  odl_link_if link_b ();

  always #50 clk = ~clk;

  // The second converter hangs off the first one's chain output.
  always_comb begin
    link_b.frame_sync_n           = link_a.frame_sync_n;
    link_b.serial_shift_clock     = link_a.serial_shift_clock | glk;
    link_b.serial_data_in         = link_a.serial_chain_out;
    link_b.output_update_strobe_n = link_a.output_update_strobe_n;
    link_b.output_clear_n         = link_a.output_clear_n;
    link_b.device_select_pin      = sel_b;
  end

  odl_host_end #(.DIV_HALF(H)) odl_host_end_i (
    .CLK(clk), .RST(rst), .CE(ce), .WORD_VALID(wvalid), .WORD_DATA(wdata),
    .WORD_LSB_FIRST(lsb), .BYTE_MODE(byt), .HOLD_FRAME(hold), .SELECT_LEVEL(sel),
    .UPDATE_REQ(upd), .CLEAR_REQ(clr), .REQ_READY(ready), .BUSY(busy),
    .RB_DATA(rb_data), .RB_VALID(rb_valid), .LINK(link_a));
  odl_dac_end odl_dac_end_i (.CLK(clk), .RST(rst), .CE(ce), .LINK(link_a),
    .DAC_CODES(codes1), .INPUT_CODES(in1), .WORD_TAKEN(tk1));
  odl_dac_end odl_dac_end_b_i (.CLK(clk), .RST(rst), .CE(ce), .LINK(link_b),
    .DAC_CODES(codes2), .INPUT_CODES(in2), .WORD_TAKEN(tk2));
  odl_link_props #(.DIV_HALF(H)) odl_link_props_i (.CLK(clk), .RST(rst),
    .frame_sync_n(link_a.frame_sync_n), .serial_shift_clock(link_a.serial_shift_clock),
    .serial_data_in(link_a.serial_data_in), .serial_chain_out(link_a.serial_chain_out),
    .output_update_strobe_n(link_a.output_update_strobe_n));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [95:0] pk(input logic [11:0] m [8]);
    for (int c = 0; c < 8; c++) pk[c*12+:12] = m[c];
  endfunction

  function automatic logic [15:0] rev(input logic [15:0] v);
    for (int k = 0; k < 16; k++) rev[k] = v[15-k];
  endfunction

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Holds the request until the edge at which the host is ready to take it.
  task automatic take;
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) errors++;
    @(posedge clk);
  endtask

  task automatic settle;
    @(posedge clk);
    take();
    repeat (12) @(negedge clk);
  endtask

  task automatic send(input logic [15:0] x, input logic l, input logic b, input logic f,
                      input logic s);
    @(posedge clk);
    wvalid <= 1'b1;
    wdata <= l ? rev(x) : x;
    lsb <= l;
    byt <= b;
    hold <= f;
    sel <= s;
    take();
    wvalid <= 1'b0;
    rbq.push_back({80'h0, last_w});
    if (x[3] == s) begin
      m1[x[2:0]] = x[15:4];
      q1.push_back(pk(m1));
    end
    if (last_w[3] == sel_b) begin
      m2[last_w[2:0]] = last_w[15:4];
      q2.push_back(pk(m2));
    end
    last_w = x;
    @(negedge clk);
    check({94'h0, busy, link_a.frame_sync_n}, 96'h2);
  endtask

  task automatic pulse(input logic u, input logic c);
    @(posedge clk);
    upd <= u;
    clr <= c;
    take();
    upd <= 1'b0;
    clr <= 1'b0;
  endtask

  // ************************************************************
  // Result monitor
  // ************************************************************
  always @(negedge clk) begin
    if (rb_valid === 1'b1) check({80'h0, rb_data}, rbq.size() ? rbq.pop_front() : 'x);
    if (tk1 === 1'b1) check(in1, q1.size() ? q1.pop_front() : 'x);
    if (tk2 === 1'b1) check(in2, q2.size() ? q2.pop_front() : 'x);
  end

  initial begin
    #(100 * 30000);
    errors++;
    end_of_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    seed = 88740;
    errors = 0;
    check_count = 0;
    {rst, ce, wvalid, lsb, byt, hold, sel, upd, clr, glk, sel_b} = 11'h601;
    wdata = 16'h0000;
    last_w = 16'h0000;
    for (int c = 0; c < 8; c++) {m1[c], m2[c]} = 24'h000000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({95'h0, link_a.frame_sync_n}, 96'h1);
    check(codes1, 96'h0);
    for (int i = 0; i < 12; i++) begin
      w = 16'($random(seed));
      w[2:0] = i[2:0];
      if (i == 10) w[15] = ~w[9];
      if (i == 10) keep = w;
      send(w, i[1], i[0], i[2], 1'($random(seed)));
      // Freeze inside a held frame while the clock is low; the word would
      // long be over if the enable did not stop the host.
      if (i == 6) begin
        @(posedge clk);
        ce <= 1'b0;
        repeat (200) @(negedge clk);
        check({94'h0, busy, link_a.frame_sync_n}, 96'h2);
        @(posedge clk);
        ce <= 1'b1;
      end
      if (i == 5) begin
        pulse(1'b1, 1'b0);
        settle();
        check(codes1, pk(m1));
        check(codes2, pk(m2));
      end
    end
    settle();
    repeat (6) begin
      @(posedge clk);
      glk <= 1'b1;
      @(posedge clk);
      glk <= 1'b0;
    end
    @(negedge clk);
    check({95'h0, link_b.serial_chain_out}, {95'h0, keep[15]});
    repeat (2) send(16'($random(seed)) | 16'h0008, 1'b0, 1'b0, 1'b0, 1'b0);
    pulse(1'b1, 1'b0);
    settle();
    check(codes1, pk(m1));
    check(codes2, pk(m2));
    pulse(1'b0, 1'b1);
    settle();
    check(codes1 | in1 | codes2 | in2, 96'h0);
    check(96'(rbq.size() + q1.size() + q2.size()), 96'h0);
    end_of_test();
  end
endmodule
